// File: hw/nota_pkg.sv
// types shared by the nand otp area modules
// assumes the constant header is on the include path
package nota_pkg;
  `include "nota_regs.svh"
  typedef logic [7:0] nota_byte_t;
  typedef logic [8*`NOTA_PAGE_BYTES-1:0] nota_page_t;
  typedef logic [19:0] nota_count_t;
  // command sequencer states
  typedef enum logic [3:0] {
    NOTA_IDLE, NOTA_FEAT_ADDR, NOTA_FEAT_DATA, NOTA_PROG_ADDR, NOTA_PROG_DATA,
    NOTA_COLW_ADDR, NOTA_READ_ADDR, NOTA_READ_DATA, NOTA_COLR_ADDR
  } nota_state_e;
  // operation running on the busy timer
  typedef enum logic [2:0] {
    NOTA_OP_NONE, NOTA_OP_LOAD, NOTA_OP_PROG, NOTA_OP_PROTECT, NOTA_OP_REJECT
  } nota_op_e;
endpackage

// File: hw/nota_regs.svh
// constants of the nand otp area block: bus offsets, field positions, codes, timing
// assumes inclusion by bare name from the package and the test modules
`ifndef NOTA_REGS_SVH
`define NOTA_REGS_SVH
// clock
`define NOTA_CLK_PERIOD_NS 10
// bus offsets (byte addresses, one word each)
`define NOTA_OFS_CMD 8'h00
`define NOTA_OFS_ADDR 8'h04
`define NOTA_OFS_DATA 8'h08
`define NOTA_OFS_CTRL 8'h0c
// control register fields
`define NOTA_CTRL_RDY 0
`define NOTA_CTRL_OTP 1
`define NOTA_CTRL_PROT 2
`define NOTA_CTRL_SYNC 3
`define NOTA_CTRL_BADCMD 4
// command codes
`define NOTA_CMD_READ 8'h00
`define NOTA_CMD_READ_GO 8'h30
`define NOTA_CMD_PROG 8'h80
`define NOTA_CMD_PROG_GO 8'h10
`define NOTA_CMD_COLW 8'h85
`define NOTA_CMD_COLR 8'h05
`define NOTA_CMD_COLR_GO 8'he0
`define NOTA_CMD_STATUS 8'h70
`define NOTA_CMD_STATUS_ENH 8'h78
`define NOTA_CMD_ERASE 8'h60
`define NOTA_CMD_SETFEAT 8'hef
`define NOTA_CMD_RESET 8'hff
// otp feature
`define NOTA_FEAT_OTP 8'h90
`define NOTA_OTP_ON 8'h01
`define NOTA_OTP_OFF 8'h00
// otp area layout
`define NOTA_PROTECT_PAGE 8'h01
`define NOTA_FIRST_PAGE 8'h02
`define NOTA_PAGE_COUNT 30
`define NOTA_PARTIAL_LIMIT 3'h4
`define NOTA_PAGE_BYTES 16
`define NOTA_ERASED_BYTE 8'hff
`define NOTA_PROTECT_DATA 8'h00
// status byte fields and the reject value
`define NOTA_ST_FAIL 0
`define NOTA_ST_ARRAY_READY_FLAG 5
`define NOTA_ST_RDY 6
`define NOTA_ST_WPN 7
`define NOTA_STATUS_REJECT 8'h60
// busy times in ns and derived cycle counts (rounded up)
`define NOTA_REJECT_TIME_NS 30000
`define NOTA_PROG_TIME_NS 600000
`define NOTA_LOAD_TIME_NS 50000
`define NOTA_REJECT_CYCLES ((`NOTA_REJECT_TIME_NS + `NOTA_CLK_PERIOD_NS - 1) / `NOTA_CLK_PERIOD_NS)
`define NOTA_PROG_CYCLES ((`NOTA_PROG_TIME_NS + `NOTA_CLK_PERIOD_NS - 1) / `NOTA_CLK_PERIOD_NS)
`define NOTA_LOAD_CYCLES ((`NOTA_LOAD_TIME_NS + `NOTA_CLK_PERIOD_NS - 1) / `NOTA_CLK_PERIOD_NS)
`endif

// File: hw/nota_store.sv
// otp page store: 32 page slots and the protection latch
// assumes one write or protect request per cycle from the sequencer
`timescale 1ns/1ps
module nota_store import nota_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write side
  input wire logic wrEn,
  input wire logic [4:0] wrPage,
  input wire nota_page_t wrData,
  input wire logic protSet,
  // read side
  input wire logic [4:0] rdPage,
  output nota_page_t rdData,
  output logic prot
);
  typedef struct packed {
    logic [31:0][8*`NOTA_PAGE_BYTES-1:0] mem; // page contents
    logic prot;                               // area locked
    logic [4:0] lastPage;                     // helper: last written page
    nota_page_t lastOld;                      // helper: its old value
  } nota_store_s;
  nota_store_s s_r;
  nota_store_s s_nxt;

  assign rdData = s_r.mem[rdPage];
  assign prot = s_r.prot;

  // and-merge keeps programmed zeros; protection only ever sets
  always_comb begin
    s_nxt = s_r;
    if (wrEn) begin
      s_nxt.mem[wrPage] = s_r.mem[wrPage] & wrData;
      s_nxt.lastPage = wrPage;
      s_nxt.lastOld = s_r.mem[wrPage];
    end
    if (protSet) begin
      s_nxt.prot = 1'b1;
    end
  end

  // reset models a new part: all bits one, unlocked
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.mem <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  no_bit_set_a: assert property (@(posedge clk) disable iff (!nrst)
    wrEn |=> (s_r.mem[s_r.lastPage] & ~s_r.lastOld) == '0)
    else $error("programming raised a zero bit");
  prot_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    s_r.prot |=> s_r.prot) else $error("protection was cleared");
endmodule

// File: hw/nota_timer.sv
// busy timer: counts down a loaded number of cycles
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module nota_timer import nota_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire nota_count_t load,
  // state
  output logic busy,
  output logic done
);
  typedef struct packed {
    nota_count_t cnt; // cycles still to run
  } nota_timer_s;
  nota_timer_s s_r;
  nota_timer_s s_nxt;

  // busy while counting, done on the last counted cycle
  assign busy = (s_r.cnt != '0);
  assign done = (s_r.cnt == 20'h1);

  // load on start, else count down to zero
  always_comb begin
    s_nxt = s_r;
    if (start) begin
      s_nxt.cnt = load;
    end else if (busy) begin
      s_nxt.cnt = s_r.cnt - 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  timer_start_a: assert property (@(posedge clk) disable iff (!nrst)
    start && load != '0 |=> busy) else $error("timer did not start");
endmodule

// File: hw/nota_top.sv
// nand otp area access: command sequencer behind a wishbone slave
// assumes a classic wishbone master on clk; commands, addresses and data
// arrive as byte writes to the command, address and data registers
// How it works
// - otp bits start at one, only cleared
// - erase never touches otp; invalid in otp mode
// - feature 90h with 01h,00h,00h,00h enters otp mode
// - otp mode steers page read and program
// - 30 pages from 02h, lock page 01h, 4 partials
// - out of range program: reject busy, wp reads 0
// - program after lock: reject busy, status 60h
// - 80h, lock page, 00h data, 10h locks area
// - repeated lock: reject busy, status 60h
// - lock is permanent
// - feature 90h with all zeros leaves otp mode
// - reset command leaves otp mode, async interface
// - page program busy for array program time
// - poll with 70h only (78h is taken as 70h here); ready bit mirrors pin
// - 85h moves write column during data input
// - 00h,addr,30h loads page; 00h resumes output
// - out of range read returns undefined data
// - 05h-e0h moves read column; no 06h
// - reads work before and after locking
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module nota_top import nota_pkg::*; #(
  parameter int unsigned REJECT_CYCLES = `NOTA_REJECT_CYCLES,
  parameter int unsigned PROG_CYCLES = `NOTA_PROG_CYCLES,
  parameter int unsigned LOAD_CYCLES = `NOTA_LOAD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // target state
  output logic readyBusyN,
  output logic otpModeActive,
  output logic syncIfActive
);
  typedef struct packed {
    nota_state_e st;             // sequencer state
    nota_op_e op;                // operation on the timer
    logic [2:0] addrCnt;         // address cycles taken
    logic [15:0] col;            // column pointer
    logic [7:0] row0;            // page address byte
    logic [15:0] rowHi;          // block address bytes
    logic [7:0] featAddr;        // feature address
    logic [1:0] paramCnt;        // feature parameter index
    logic [7:0] featFirst;       // first parameter
    logic featRestZero;          // later parameters all zero
    logic [4:0] opPage;          // page slot of the operation
    logic opValid;               // read page in range
    nota_page_t cache;           // program data
    nota_page_t readBuf;         // loaded page for output
    logic [31:0][2:0] partials;  // partial programs per page
    logic otpMode;               // otp operation mode
    logic syncIf;                // synchronous interface active
    logic badCmd;                // erase seen in otp mode, sticky
    logic statusOut;             // data reads return status
    logic fail;                  // status fail bit
    logic wpN;                   // status write-protect bit, 0 after a rejected program
    logic ack;                   // bus acknowledge
    logic [31:0] dat;            // bus read data
    logic readyBusyN;            // ready high, busy low
  } nota_top_s;
  nota_top_s s_r;
  nota_top_s s_nxt;

  // bus decode
  logic req;
  logic [7:0] wrByte;
  logic [7:0] wordAdr;
  // timer and store links
  logic tStart;
  nota_count_t tLoad;
  logic tBusy;
  logic tDone;
  logic wrEn;
  logic protSet;
  logic prot;
  nota_page_t rdData;
  // derived view of state
  logic [7:0] statByte;
  logic [7:0] lastPage;
  logic pageInRange;
  // event strobes, also watched by the checks below
  logic featEnter;
  logic featExit;
  logic eraseCmd;
  logic resetCmd;
  logic rejectStart;
  logic progStart;
  logic loadStart;
  logic statRead;

  assign wrByte = dat_i[7:0];
  assign wordAdr = {adr_i[7:2], 2'b00};
  assign lastPage = 8'(`NOTA_FIRST_PAGE + `NOTA_PAGE_COUNT - 1);
  // block 0 and page inside the otp window
  assign pageInRange = (s_r.rowHi == '0) && (s_r.row0 >= `NOTA_FIRST_PAGE)
    && (s_r.row0 <= lastPage);

  // ready bit and array ready flag both follow the pin
  always_comb begin
    statByte = 8'h00;
    statByte[`NOTA_ST_FAIL] = s_r.fail;
    statByte[`NOTA_ST_ARRAY_READY_FLAG] = s_r.readyBusyN;
    statByte[`NOTA_ST_RDY] = s_r.readyBusyN;
    statByte[`NOTA_ST_WPN] = s_r.wpN;
  end

  nota_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(tStart),
    .load(tLoad),
    .busy(tBusy),
    .done(tDone)
  );

  nota_store u_store (
    .clk(clk),
    .nrst(nrst),
    .wrEn(wrEn),
    .wrPage(s_r.opPage),
    .wrData(s_r.cache),
    .protSet(protSet),
    .rdPage(s_r.opPage),
    .rdData(rdData),
    .prot(prot)
  );

  // sequencer, bus slave and timer completion in one next-state process
  always_comb begin
    s_nxt = s_r;
    featEnter = 1'b0;
    featExit = 1'b0;
    eraseCmd = 1'b0;
    resetCmd = 1'b0;
    rejectStart = 1'b0;
    progStart = 1'b0;
    loadStart = 1'b0;
    statRead = 1'b0;
    tStart = 1'b0;
    tLoad = '0;
    wrEn = 1'b0;
    protSet = 1'b0;
    // one-cycle answer; ack never stays high two cycles
    req = cyc_i && stb_i && !s_r.ack;
    s_nxt.ack = req;

    // finish the running operation
    if (tDone) begin
      unique case (s_r.op)
        NOTA_OP_NONE: begin
        end
        NOTA_OP_LOAD: begin
          // out of range reads give erased filler, meaningless by contract
          s_nxt.readBuf = s_r.opValid ? rdData : '1;
        end
        NOTA_OP_PROG: begin
          if (s_r.partials[s_r.opPage] < `NOTA_PARTIAL_LIMIT) begin
            wrEn = 1'b1;
            s_nxt.partials[s_r.opPage] = s_r.partials[s_r.opPage] + 3'h1;
          end else begin
            s_nxt.fail = 1'b1;
          end
        end
        NOTA_OP_PROTECT: begin
          // only the documented zero first byte locks the area
          if (s_r.cache[7:0] == `NOTA_PROTECT_DATA) begin
            protSet = 1'b1;
          end else begin
            s_nxt.fail = 1'b1;
          end
        end
        NOTA_OP_REJECT: begin
          s_nxt.wpN = 1'b0;
          s_nxt.fail = 1'b0;
        end
      endcase
      s_nxt.op = NOTA_OP_NONE;
    end

    // register writes
    if (req && we_i && sel_i[0]) begin
      if (wordAdr == `NOTA_OFS_CMD) begin
        if (wrByte == `NOTA_CMD_RESET) begin
          resetCmd = 1'b1;
          s_nxt.st = NOTA_IDLE;
          s_nxt.statusOut = 1'b0;
          if (s_r.otpMode) begin
            s_nxt.otpMode = 1'b0;
            s_nxt.syncIf = 1'b0;
          end
        end else if (wrByte == `NOTA_CMD_STATUS || wrByte == `NOTA_CMD_STATUS_ENH) begin
          // enhanced status is barred in otp mode; tolerated as plain status
          s_nxt.statusOut = 1'b1;
        end else if (tBusy) begin
          // other commands are ignored while busy
        end else if (wrByte == `NOTA_CMD_SETFEAT) begin
          s_nxt.st = NOTA_FEAT_ADDR;
        end else if (wrByte == `NOTA_CMD_READ) begin
          s_nxt.st = NOTA_READ_ADDR;
          s_nxt.addrCnt = 3'h0;
          s_nxt.statusOut = 1'b0;
        end else if (wrByte == `NOTA_CMD_READ_GO) begin
          s_nxt.st = NOTA_IDLE;
          if (s_r.st == NOTA_READ_ADDR && s_r.addrCnt == 3'h5 && s_r.otpMode) begin
            loadStart = 1'b1;
            tStart = 1'b1;
            tLoad = nota_count_t'(LOAD_CYCLES);
            s_nxt.op = NOTA_OP_LOAD;
            s_nxt.opPage = s_r.row0[4:0];
            s_nxt.opValid = pageInRange;
            s_nxt.st = NOTA_READ_DATA;
          end
        end else if (wrByte == `NOTA_CMD_PROG) begin
          // main array program is handled elsewhere
          s_nxt.st = NOTA_IDLE;
          if (s_r.otpMode) begin
            s_nxt.st = NOTA_PROG_ADDR;
            s_nxt.addrCnt = 3'h0;
            s_nxt.cache = '1;
          end
        end else if (wrByte == `NOTA_CMD_COLW && s_r.st == NOTA_PROG_DATA) begin
          s_nxt.st = NOTA_COLW_ADDR;
          s_nxt.addrCnt = 3'h0;
        end else if (wrByte == `NOTA_CMD_PROG_GO && s_r.st == NOTA_PROG_DATA) begin
          tStart = 1'b1;
          s_nxt.st = NOTA_IDLE;
          s_nxt.fail = 1'b0;
          s_nxt.wpN = 1'b1;
          s_nxt.opPage = s_r.row0[4:0];
          if (prot || (!pageInRange && s_r.row0 != `NOTA_PROTECT_PAGE)
              || (s_r.row0 == `NOTA_PROTECT_PAGE && s_r.rowHi != '0)) begin
            rejectStart = 1'b1;
            tLoad = nota_count_t'(REJECT_CYCLES);
            s_nxt.op = NOTA_OP_REJECT;
          end else if (s_r.row0 == `NOTA_PROTECT_PAGE) begin
            progStart = 1'b1;
            tLoad = nota_count_t'(PROG_CYCLES);
            s_nxt.op = NOTA_OP_PROTECT;
          end else begin
            progStart = 1'b1;
            tLoad = nota_count_t'(PROG_CYCLES);
            s_nxt.op = NOTA_OP_PROG;
          end
        end else if (wrByte == `NOTA_CMD_COLR && (s_r.st == NOTA_READ_DATA
                     || (s_r.st == NOTA_READ_ADDR && s_r.addrCnt == 3'h0))) begin
          // a bare 00h after status polling is already data output mode
          s_nxt.st = NOTA_COLR_ADDR;
          s_nxt.addrCnt = 3'h0;
        end else if (wrByte == `NOTA_CMD_COLR_GO && s_r.st == NOTA_COLR_ADDR
                     && s_r.addrCnt == 3'h2) begin
          s_nxt.st = NOTA_READ_DATA;
          s_nxt.statusOut = 1'b0;
        end else if (wrByte == `NOTA_CMD_ERASE && s_r.otpMode) begin
          eraseCmd = 1'b1;
          s_nxt.badCmd = 1'b1;
          s_nxt.st = NOTA_IDLE;
        end else begin
          // anything else belongs to the main array logic
          s_nxt.st = NOTA_IDLE;
        end
      end else if (wordAdr == `NOTA_OFS_ADDR) begin
        if (s_r.st == NOTA_FEAT_ADDR) begin
          s_nxt.featAddr = wrByte;
          s_nxt.paramCnt = 2'h0;
          s_nxt.st = NOTA_FEAT_DATA;
        end else if (s_r.st == NOTA_PROG_ADDR || s_r.st == NOTA_READ_ADDR) begin
          // column low, column high, page, block low, block high
          case (s_r.addrCnt)
            3'h0: s_nxt.col[7:0] = wrByte;
            3'h1: s_nxt.col[15:8] = wrByte;
            3'h2: s_nxt.row0 = wrByte;
            3'h3: s_nxt.rowHi[7:0] = wrByte;
            3'h4: s_nxt.rowHi[15:8] = wrByte;
            default: begin
            end
          endcase
          if (s_r.addrCnt != 3'h5) begin
            s_nxt.addrCnt = s_r.addrCnt + 3'h1;
          end
          if (s_r.st == NOTA_PROG_ADDR && s_r.addrCnt == 3'h4) begin
            s_nxt.st = NOTA_PROG_DATA;
          end
        end else if (s_r.st == NOTA_COLW_ADDR || s_r.st == NOTA_COLR_ADDR) begin
          // two column cycles, then back to data input or wait for e0h
          if (s_r.addrCnt == 3'h0) begin
            s_nxt.col[7:0] = wrByte;
          end else if (s_r.addrCnt == 3'h1) begin
            s_nxt.col[15:8] = wrByte;
            if (s_r.st == NOTA_COLW_ADDR) begin
              s_nxt.st = NOTA_PROG_DATA;
            end
          end
          if (s_r.addrCnt != 3'h2) begin
            s_nxt.addrCnt = s_r.addrCnt + 3'h1;
          end
        end
      end else if (wordAdr == `NOTA_OFS_DATA) begin
        if (s_r.st == NOTA_FEAT_DATA) begin
          s_nxt.paramCnt = s_r.paramCnt + 2'h1;
          if (s_r.paramCnt == 2'h0) begin
            s_nxt.featFirst = wrByte;
            s_nxt.featRestZero = 1'b1;
          end else if (wrByte != 8'h00) begin
            s_nxt.featRestZero = 1'b0;
          end
          if (s_r.paramCnt == 2'h3) begin
            s_nxt.st = NOTA_IDLE;
            if (s_r.featAddr == `NOTA_FEAT_OTP && s_r.featRestZero && wrByte == 8'h00) begin
              if (s_r.featFirst == `NOTA_OTP_ON) begin
                featEnter = 1'b1;
                s_nxt.otpMode = 1'b1;
              end else if (s_r.featFirst == `NOTA_OTP_OFF) begin
                featExit = 1'b1;
                s_nxt.otpMode = 1'b0;
              end
            end
          end
        end else if (s_r.st == NOTA_PROG_DATA) begin
          // bytes past the page end are dropped
          if (s_r.col[15:4] == '0) begin
            s_nxt.cache[{s_r.col[3:0], 3'b000} +: 8] = wrByte;
          end
          s_nxt.col = s_r.col + 16'h1;
        end
      end else if (wordAdr == `NOTA_OFS_CTRL) begin
        s_nxt.syncIf = dat_i[`NOTA_CTRL_SYNC];
        if (dat_i[`NOTA_CTRL_BADCMD]) begin
          s_nxt.badCmd = 1'b0;
        end
      end
    end

    // register reads; unmapped words read zero
    if (req && !we_i) begin
      s_nxt.dat = 32'h0000_0000;
      if (wordAdr == `NOTA_OFS_DATA) begin
        if (s_r.statusOut) begin
          statRead = 1'b1;
          s_nxt.dat[7:0] = statByte;
        end else if (s_r.st == NOTA_READ_DATA
                     || (s_r.st == NOTA_READ_ADDR && s_r.addrCnt == 3'h0)) begin
          // 00h alone after polling resumes output at the column
          s_nxt.st = NOTA_READ_DATA;
          s_nxt.dat[7:0] = `NOTA_ERASED_BYTE;
          if (s_r.col[15:4] == '0) begin
            s_nxt.dat[7:0] = s_r.readBuf[{s_r.col[3:0], 3'b000} +: 8];
          end
          s_nxt.col = s_r.col + 16'h1;
        end
      end else if (wordAdr == `NOTA_OFS_CTRL) begin
        s_nxt.dat[`NOTA_CTRL_RDY] = s_r.readyBusyN;
        s_nxt.dat[`NOTA_CTRL_OTP] = s_r.otpMode;
        s_nxt.dat[`NOTA_CTRL_PROT] = prot;
        s_nxt.dat[`NOTA_CTRL_SYNC] = s_r.syncIf;
        s_nxt.dat[`NOTA_CTRL_BADCMD] = s_r.badCmd;
      end
    end

    // pin low from the cycle after a start until the count runs out
    s_nxt.readyBusyN = !(tStart || (tBusy && !tDone));
  end

  // power up leaves normal mode, ready, not write protected
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.readyBusyN <= 1'b1;
      s_r.wpN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dat_o = s_r.dat;
  assign ack_o = s_r.ack;
  assign readyBusyN = s_r.readyBusyN;
  assign otpModeActive = s_r.otpMode;
  assign syncIfActive = s_r.syncIf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  otp_enter_a: assert property (featEnter |=> s_r.otpMode)
    else $error("otp mode not entered");
  otp_exit_a: assert property (featExit |=> !s_r.otpMode && s_r.st == NOTA_IDLE)
    else $error("otp mode not left");
  erase_ignored_a: assert property (eraseCmd |=> s_r.badCmd && s_r.readyBusyN)
    else $error("erase acted in otp mode");
  reset_exit_a: assert property (resetCmd && s_r.otpMode |=> !s_r.otpMode && !s_r.syncIf)
    else $error("reset left otp mode active");
  reject_done_a: assert property (tDone && s_r.op == NOTA_OP_REJECT
    |=> s_r.readyBusyN && statByte == `NOTA_STATUS_REJECT) else $error("reject status wrong");
  reject_busy_a: assert property (rejectStart |=> !s_r.readyBusyN [*2])
    else $error("reject not busy");
  prog_busy_a: assert property (progStart |=> !s_r.readyBusyN && s_r.op != NOTA_OP_NONE)
    else $error("program not busy");
  load_busy_a: assert property (loadStart |=> !s_r.readyBusyN && s_r.st == NOTA_READ_DATA)
    else $error("page load not busy");
  rdy_mirror_a: assert property (statRead |=> s_r.dat[`NOTA_ST_RDY] == $past(s_r.readyBusyN))
    else $error("status ready bit differs from pin");
  power_up_a: assert property (disable iff (1'b0) !nrst |=> !s_r.otpMode && s_r.readyBusyN)
    else $error("otp mode after power up");
  ack_pulse_a: assert property (s_r.ack |=> !s_r.ack) else $error("ack held two cycles");

  enter_cov: cover property (featEnter);
  reject_cov: cover property (rejectStart);
  protect_cov: cover property (progStart ##1 s_r.op == NOTA_OP_PROTECT);
  load_cov: cover property (loadStart);
endmodule

// File: test/nota_host.sv
// host model: wishbone master sending nand command, address and data bytes
// assumes a slave that acks every request; it checks nothing itself
`timescale 1ns/1ps
`include "nota_regs.svh"
module nota_host (
  // clock
  input wire logic clk,
  // wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [31:0] dat,
  input wire logic [31:0] rd,
  input wire logic ack
);
  // idle bus from time zero
  initial {cyc, stb, we, adr, dat} = '0;
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask
  // single byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  // five address cycles, block always 0
  task automatic addr5(input logic [7:0] col, input logic [7:0] pg);
    logic [7:0] seq [5];
    seq = '{col, 8'h00, pg, 8'h00, 8'h00};
    foreach (seq[i]) wr(`NOTA_OFS_ADDR, seq[i]);
  endtask
  // feature 90h: p1 given, p2..p4 zero
  task automatic feat(input logic [7:0] v);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_SETFEAT);
    wr(`NOTA_OFS_ADDR, `NOTA_FEAT_OTP);
    wr(`NOTA_OFS_DATA, v);
    repeat (3) wr(`NOTA_OFS_DATA, 8'h00);
  endtask
  // program b at column 0, then moves to column 3 and writes b again
  task automatic prog(input logic [7:0] pg, input logic [7:0] b);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_PROG);
    addr5(8'h00, pg);
    wr(`NOTA_OFS_DATA, b);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_COLW);
    wr(`NOTA_OFS_ADDR, 8'h03);
    wr(`NOTA_OFS_ADDR, 8'h00);
    wr(`NOTA_OFS_DATA, b);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_PROG_GO);
  endtask
  // plain status only, never the enhanced form
  task automatic poll(output logic [7:0] q);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_STATUS);
    do bus(1'b0, `NOTA_OFS_DATA, 8'h00, q); while (q[6] !== 1'b1);
  endtask
  // load page, poll, resume data, then jump to col with 05h-e0h
  task automatic rdpg(input logic [7:0] pg, input logic [7:0] col,
      output logic [7:0] q);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_READ);
    addr5(8'h00, pg);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_READ_GO);
    poll(q);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_READ);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_COLR);
    wr(`NOTA_OFS_ADDR, col);
    wr(`NOTA_OFS_ADDR, 8'h00);
    wr(`NOTA_OFS_CMD, `NOTA_CMD_COLR_GO);
    bus(1'b0, `NOTA_OFS_DATA, 8'h00, q);
  endtask
endmodule

// File: test/tb_top.sv
// bench: drives the otp block through the host model, checks its ports
// assumes short busy counts so the run stays brief
`timescale 1ns/1ps
`include "nota_regs.svh"
module tb_top;
  localparam int P = 8;
  localparam int R = 5;
  // one program step and what it should give
  typedef struct {logic [7:0] pg, b, st, rv; int busy; bit rdOn;} nota_row_s;
  logic clk, nrst, cyc, stb, we, ack, rbn, otp, sy;
  logic [7:0] adr, q;
  logic [31:0] dat, rd;
  int lowCnt = 0, cycles = 0, errTotal = 0, samplesChecked = 0;
  // pages in ascending order until the lock
  nota_row_s rows [10] = '{'{8'h02, 8'ha5, 8'he0, 8'ha5, P, 1'b1},
    '{8'h02, 8'h3c, 8'he0, 8'h24, P, 1'b1}, '{8'h02, 8'hff, 8'he0, 8'h24, P, 1'b0},
    '{8'h02, 8'hff, 8'he0, 8'h24, P, 1'b0}, '{8'h02, 8'h00, 8'he1, 8'h24, P, 1'b1},
    '{8'h1f, 8'h0f, 8'he0, 8'h0f, P, 1'b1}, '{8'h20, 8'h00, 8'h60, 8'hff, R, 1'b1},
    '{8'h01, 8'h00, 8'he0, 8'h00, P, 1'b0}, '{8'h03, 8'h00, 8'h60, 8'hff, R, 1'b1},
    '{8'h01, 8'h00, 8'h60, 8'h00, R, 1'b0}};
  // byte writes only need sel bit 0, so all lanes stay on
  nota_top #(.REJECT_CYCLES(R), .PROG_CYCLES(P), .LOAD_CYCLES(4)) uut (.clk(clk),
    .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
    .dat_i(dat), .dat_o(rd), .ack_o(ack), .readyBusyN(rbn), .otpModeActive(otp),
    .syncIfActive(sy));
  nota_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(dat),
    .rd(rd), .ack(ack));
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // busy length and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!rbn) lowCnt <= lowCnt + 1;
    if (cycles == 20000) begin
      errTotal++;
      giveVerdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic giveVerdict();
    if (errTotal == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({rbn, otp, sy}, 3'h4);
    host.feat(`NOTA_OTP_ON);
    repeat (2) @(posedge clk);
    chk(otp, 1'b1);
    foreach (rows[i]) begin
      lowCnt = 0;
      host.prog(rows[i].pg, rows[i].b);
      host.poll(q);
      chk(q, rows[i].st);
      chk(lowCnt, rows[i].busy);
      if (rows[i].rdOn) begin
        host.rdpg(rows[i].pg, 8'h00, q);
        chk(q, rows[i].rv);
        host.rdpg(rows[i].pg, 8'h03, q);
        chk(q, rows[i].rv);
      end
    end
    // erase refused in otp mode, lock shown
    host.wr(`NOTA_OFS_CMD, `NOTA_CMD_ERASE);
    host.bus(1'b0, `NOTA_OFS_CTRL, 8'h00, q);
    chk(q[4:0], 5'h17);
    host.feat(`NOTA_OTP_OFF);
    repeat (2) @(posedge clk);
    chk(otp, 1'b0);
    // reset command drops otp mode and the sync flag, not the lock
    host.feat(`NOTA_OTP_ON);
    host.wr(`NOTA_OFS_CTRL, 8'h08);
    host.wr(`NOTA_OFS_CMD, `NOTA_CMD_RESET);
    repeat (2) @(posedge clk);
    chk({otp, sy}, 2'h0);
    host.bus(1'b0, `NOTA_OFS_CTRL, 8'h00, q);
    chk(q[4:0], 5'h15);
    host.bus(1'b0, 8'h10, 8'h00, q);
    chk(q, 8'h00);
    giveVerdict();
  end
endmodule
